// ===== hdl/tpwm_pkg.sv
package tpwm_pkg;

  // Counter and byte widths
  localparam int TPWM_CNT_W = 16;
  localparam int TPWM_BYTE_W = 8;

  // Counter value after reset, after a period match in PWM mode and on a single shot restart
  localparam logic [15:0] TPWM_RELOAD = 16'hFFFC;
  // Counts spent between the reload point and zero plus the match cycle
  localparam logic [15:0] TPWM_TICK_OFFSET = 16'h0005;

  // Timer clock selection codes
  localparam logic [1:0] TPWM_SEL_DIV4 = 2'h0;
  localparam logic [1:0] TPWM_SEL_DIV2 = 2'h1;
  localparam logic [1:0] TPWM_SEL_DIV8 = 2'h2;
  localparam logic [1:0] TPWM_SEL_EXT = 2'h3;

  // Prescale factors
  localparam logic [3:0] TPWM_DIV2 = 4'h2;
  localparam logic [3:0] TPWM_DIV4 = 4'h4;
  localparam logic [3:0] TPWM_DIV8 = 4'h8;

  // Reset values of control state
  localparam logic [2:0] TPWM_PRE_RST = 3'h0;
  localparam logic [15:0] TPWM_VAL_RST = 16'h0000;

  // Control bits from software
  typedef struct packed {
    logic pwm_mode;
    logic single_shot_mode;
    logic compare1_pin_enable;
    logic first_match_level;
    logic period_match_level;
    logic [1:0] timer_clock_select;
    logic capture_irq_enable;
    logic global_irq_mask;
  } tpwm_ctrl_s;

  // Sticky status flags
  typedef struct packed {
    logic compare1_flag;
    logic compare2_flag;
    logic capture1_flag;
    logic capture2_flag;
  } tpwm_flags_s;

  // Flag clear strobes, one per flag
  typedef struct packed {
    logic clr_compare1;
    logic clr_compare2;
    logic clr_capture1;
    logic clr_capture2;
  } tpwm_clear_s;

  // Prescale factor for a clock selection code
  function automatic logic [3:0] tpwm_div_of(input logic [1:0] sel);
    case (sel)
      TPWM_SEL_DIV2: tpwm_div_of = TPWM_DIV2;
      TPWM_SEL_DIV8: tpwm_div_of = TPWM_DIV8;
      default: tpwm_div_of = TPWM_DIV4;
    endcase
  endfunction

endpackage

// ===== hdl/tpwm_prescaler.sv
`timescale 1ns/1ps
module tpwm_prescaler
  import tpwm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Selection and external tick
  input wire logic [1:0] timer_clock_select,
  input wire logic ext_tick,
  // Timer tick, one cycle wide when dividing; follows ext_tick in external mode
  output logic tick
);

  typedef struct packed {
    logic [2:0] cnt;
  } tpwm_pre_s;

  tpwm_pre_s s_q;
  tpwm_pre_s s_d;
  logic [3:0] div;

  // Divide the system clock or pass the external tick
  always_comb
  begin
    div = tpwm_div_of(timer_clock_select);
    s_d = s_q;
    if (timer_clock_select == TPWM_SEL_EXT)
    begin
      tick = ext_tick; // [R9]
      s_d.cnt = TPWM_PRE_RST;
    end
    else
    begin
      tick = (s_q.cnt == 3'(div - 4'h1)); // [R9]
      s_d.cnt = tick ? TPWM_PRE_RST : s_q.cnt + 3'h1;
    end
  end

  // State register, frozen while clock enable is low
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      s_q <= '{cnt: TPWM_PRE_RST};
    else if (clk_en)
      s_q <= s_d;
  end

endmodule // tpwm_prescaler

// ===== hdl/tpwm_timer.sv
`timescale 1ns/1ps
// Behaviour
// [R1] PWM mode owns compare 1 and period
// [R2] Shadows load only at period match
// [R3] High byte write locks until low byte
// [R4] Compare always enabled in PWM mode
// [R5] Matches drive pin to chosen levels
// [R6] Pin enable and mode bit start PWM
// [R7] Pulse length is period minus first
// [R8] Equal levels give constant output
// [R9] Timer clock divided by 2, 4, 8 or external
// [R10] Program values as ticks minus five
// [R11] Period match reloads counter to FFFC
// [R12] Compare flags never set in PWM mode
// [R13] Period match sets capture one flag
// [R14] Capture pin one ignored in PWM mode
// [R15] Capture pin two still captures
// [R16] PWM overrides single shot mode
// [R17] Counter steps and compares every tick
// [R18] Clearing mode restores normal compare
module tpwm_timer
  import tpwm_pkg::*;
#(
  parameter int CNT_W = TPWM_CNT_W
)
(
  // Clock, reset and clock enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Control bits
  input wire tpwm_ctrl_s ctrl,
  // Compare byte writes: sel 0 first, 1 period
  input wire logic cmp_wr_high,
  input wire logic cmp_wr_low,
  input wire logic cmp_wr_sel,
  input wire logic [7:0] cmp_wr_byte,
  // Timer pins, synchronous to clk_sys
  input wire logic ext_tick,
  input wire logic capture_pin_one,
  input wire logic capture_pin_two,
  // Flag clears
  input wire tpwm_clear_s flag_clear,
  // Waveform pin
  output logic waveform_output_pin,
  output logic waveform_output_oe,
  // Status
  output tpwm_flags_s flags,
  output logic timer_irq,
  output logic [CNT_W-1:0] counter,
  output logic [CNT_W-1:0] first_capture_value,
  output logic [CNT_W-1:0] second_capture_value
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] first_compare_value;
    logic [CNT_W-1:0] period_compare_value;
    logic [CNT_W-1:0] first_shadow;
    logic [CNT_W-1:0] period_shadow;
    logic [7:0] first_high_hold;
    logic [7:0] period_high_hold;
    logic first_lock;
    logic period_lock;
    logic pin;
    tpwm_flags_s flags;
    logic [CNT_W-1:0] cap1_val;
    logic [CNT_W-1:0] cap2_val;
    logic cap1_prev;
    logic cap2_prev;
  } tpwm_state_s;

  tpwm_state_s s_q;
  tpwm_state_s s_d;
  logic tick;
  logic tick_en;
  logic pwm;
  logic first_hit;
  logic period_hit;
  logic cap1_edge;
  logic cap2_edge;

  // Timer clock source
  tpwm_prescaler u_pre (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .timer_clock_select(ctrl.timer_clock_select),
    .ext_tick(ext_tick),
    .tick(tick)
  );

  // Match and edge decode
  assign tick_en = tick & clk_en;
  assign pwm = ctrl.pwm_mode; // [R16]
  assign first_hit = tick & (s_q.cnt == s_q.first_shadow); // [R4] [R17]
  assign period_hit = tick & (s_q.cnt == s_q.period_shadow); // [R17]
  assign cap1_edge = capture_pin_one & ~s_q.cap1_prev & ~pwm; // [R14]
  assign cap2_edge = capture_pin_two & ~s_q.cap2_prev; // [R15]

  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.cap1_prev = capture_pin_one;
    s_d.cap2_prev = capture_pin_two;
    // Clears first, so a same-cycle set below wins
    if (flag_clear.clr_compare1)
      s_d.flags.compare1_flag = 1'b0;
    if (flag_clear.clr_compare2)
      s_d.flags.compare2_flag = 1'b0;
    if (flag_clear.clr_capture1)
      s_d.flags.capture1_flag = 1'b0;
    if (flag_clear.clr_capture2)
      s_d.flags.capture2_flag = 1'b0;
    // Byte-locked compare writes
    if (cmp_wr_high)
    begin
      if (cmp_wr_sel)
      begin
        s_d.period_high_hold = cmp_wr_byte;
        s_d.period_lock = 1'b1; // [R3]
      end
      else
      begin
        s_d.first_high_hold = cmp_wr_byte;
        s_d.first_lock = 1'b1; // [R3]
      end
    end
    else if (cmp_wr_low)
    begin
      // Value moves on the low byte write, joined with the held high byte
      if (cmp_wr_sel)
      begin
        s_d.period_compare_value = {s_q.period_high_hold, cmp_wr_byte};
        s_d.period_lock = 1'b0; // [R3]
      end
      else
      begin
        s_d.first_compare_value = {s_q.first_high_hold, cmp_wr_byte};
        s_d.first_lock = 1'b0; // [R3]
      end
    end
    // Outside PWM mode the compares follow the values directly
    if (!pwm)
    begin
      s_d.first_shadow = s_q.first_compare_value; // [R18]
      s_d.period_shadow = s_q.period_compare_value; // [R18]
    end
    // Counter and compare actions
    if (pwm && period_hit)
    begin
      s_d.cnt = TPWM_RELOAD; // [R11] [R10]
      s_d.pin = ctrl.period_match_level; // [R5] [R7] [R8]
      s_d.flags.capture1_flag = 1'b1; // [R13]
      s_d.first_shadow = s_q.first_compare_value; // [R2]
      s_d.period_shadow = s_q.period_compare_value; // [R2]
    end
    else if (!pwm && ctrl.single_shot_mode && cap1_edge)
    begin
      // Single shot: pin edge restarts count at period level
      s_d.cnt = TPWM_RELOAD;
      s_d.pin = ctrl.period_match_level;
    end
    else if (tick)
    begin
      s_d.cnt = s_q.cnt + 16'h0001; // [R17]
      if (first_hit)
      begin
        s_d.pin = ctrl.first_match_level; // [R5] [R1]
        if (!pwm)
          s_d.flags.compare1_flag = 1'b1; // [R12] [R18]
      end
      if (!pwm && period_hit)
        s_d.flags.compare2_flag = 1'b1; // [R12] [R18]
    end
    // Input captures
    if (cap1_edge)
    begin
      s_d.cap1_val = s_q.cnt;
      s_d.flags.capture1_flag = 1'b1;
    end
    if (cap2_edge)
    begin
      s_d.cap2_val = s_q.cnt; // [R15]
      s_d.flags.capture2_flag = 1'b1; // [R15]
    end
  end

  // State register, frozen while clock enable is low
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      s_q <= '{cnt: TPWM_RELOAD, default: '0};
    else if (clk_en)
      s_q <= s_d;
  end

  // Outputs
  assign waveform_output_oe = ctrl.compare1_pin_enable; // [R6]
  assign waveform_output_pin = s_q.pin & ctrl.compare1_pin_enable; // [R6]
  assign flags = s_q.flags;
  assign counter = s_q.cnt;
  assign first_capture_value = s_q.cap1_val;
  assign second_capture_value = s_q.cap2_val;
  assign timer_irq = ctrl.capture_irq_enable & ~ctrl.global_irq_mask
    & (s_q.flags.capture1_flag | s_q.flags.capture2_flag); // [R13]

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_period_reload: assert property (pwm && tick_en // [R11]
    && period_hit |=> counter == TPWM_RELOAD)
    else $error("period match did not reload counter");
  // Pin enable may move after the match, so it gates the expectation
  a_period_level: assert property (pwm && tick_en // [R5]
    && period_hit |=> waveform_output_pin
    == ($past(ctrl.period_match_level) & ctrl.compare1_pin_enable))
    else $error("pin not at period level after match");
  a_first_level: assert property (pwm && tick_en && first_hit // [R5]
    && !period_hit |=> waveform_output_pin
    == ($past(ctrl.first_match_level) & ctrl.compare1_pin_enable))
    else $error("pin not at first level after match");
  a_cmp_flag_quiet: assert property ($rose(flags.compare1_flag) // [R12]
    || $rose(flags.compare2_flag) |-> !$past(pwm))
    else $error("compare flag set in pwm mode");
  a_cap1_from_period: assert property (pwm && tick_en // [R13]
    && period_hit |=> flags.capture1_flag)
    else $error("capture one flag missing at period match");
  a_cap1_disabled: assert property (pwm && clk_en // [R14]
    |=> $stable(first_capture_value))
    else $error("capture one loaded in pwm mode");
  a_cap2_loads: assert property (clk_en && cap2_edge // [R15]
    |=> second_capture_value == $past(counter)
    && flags.capture2_flag)
    else $error("capture two value wrong");
  a_shadow_hold: assert property (pwm && $past(pwm) && clk_en // [R2]
    && !period_hit |=> $stable(s_q.first_shadow)
    && $stable(s_q.period_shadow))
    else $error("shadow changed outside period end");
  a_lock_hold: assert property (clk_en && cmp_wr_high // [R3]
    && !cmp_wr_sel |=> $stable(s_q.first_compare_value) && s_q.first_lock)
    else $error("high byte write leaked into value");
  a_count_step: assert property (clk_en && tick && !pwm // [R17]
    && !ctrl.single_shot_mode |=> counter == $past(counter) + 16'h0001)
    else $error("counter did not step on tick");

  c_period_end: cover property (pwm && tick_en && period_hit);
  c_pwm_pulse: cover property (pwm && tick_en && first_hit
    ##[1:200] pwm && tick_en && period_hit);
  c_cap2_in_pwm: cover property (pwm && clk_en && cap2_edge);
  c_locked_write: cover property (cmp_wr_high && clk_en
    ##[1:20] cmp_wr_low && clk_en);

endmodule // tpwm_timer

// ===== verification/tpwm_pin_monitor.sv
`timescale 1ns/1ps
// Load on the waveform pin, timing it in clock cycles
module tpwm_pin_monitor
(
  // Clock and observed pin
  input wire logic clk_sys,
  input wire logic pin,
  // Last full period and last high time
  output int period,
  output int high
);
  int run;
  int rise_at;
  logic pin_q;
  // Time stamps at each edge of the pin
  always @(posedge clk_sys)
  begin
    run <= run + 1;
    pin_q <= pin;
    if (pin && !pin_q)
    begin
      period <= run - rise_at;
      rise_at <= run;
    end
    if (!pin && pin_q)
      high <= run - rise_at;
  end
  // Start values
  initial
  begin
    run = 0;
    rise_at = 0;
    pin_q = 0;
    period = 0;
    high = 0;
  end
endmodule // tpwm_pin_monitor

// ===== verification/tpwm_timer_bench.sv
`timescale 1ns/1ps
module tpwm_timer_bench
  import tpwm_pkg::*;
;
  // Design inputs
  logic clk_sys = 0;
  logic rst = 1;
  logic clk_en = 1;
  tpwm_ctrl_s ctrl = '{timer_clock_select: TPWM_SEL_EXT, default: '0};
  logic cmp_wr_high = 0;
  logic cmp_wr_low = 0;
  logic cmp_wr_sel = 0;
  logic [7:0] cmp_wr_byte = 8'h00;
  logic ext_tick = 0;
  logic capture_pin_one = 0;
  logic capture_pin_two = 0;
  tpwm_clear_s flag_clear = '0;
  // Design outputs
  logic waveform_output_pin;
  logic waveform_output_oe;
  tpwm_flags_s flags;
  logic timer_irq;
  logic [15:0] counter;
  logic [15:0] first_capture_value;
  logic [15:0] second_capture_value;
  int mon_period;
  int mon_high;
  // Reference model state
  logic [15:0] m_cnt;
  logic [15:0] m_c1;
  logic [15:0] m_c2;
  logic [15:0] m_v [2];
  logic [15:0] m_s [2];
  logic [7:0] m_hi [2];
  logic [3:0] m_fl;
  logic m_pin;
  logic m_q1;
  logic m_q2;
  logic [31:0] r;
  logic [31:0] r2;
  int dv [3] = '{4, 2, 8};
  int miscompares = 0;
  int comparisons = 0;
  int seed = 71574;
  bit chk = 0;

  // Clock
  always #50 clk_sys = ~clk_sys;

  tpwm_timer u_dut (.clk_sys, .rst, .clk_en, .ctrl, .cmp_wr_high,
    .cmp_wr_low, .cmp_wr_sel, .cmp_wr_byte, .ext_tick, .capture_pin_one,
    .capture_pin_two, .flag_clear, .waveform_output_pin,
    .waveform_output_oe, .flags, .timer_irq, .counter,
    .first_capture_value, .second_capture_value);
  tpwm_pin_monitor u_mon (.clk_sys, .pin(waveform_output_pin),
    .period(mon_period), .high(mon_high));

  // Compare one value
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One clock: advance the model, then compare
  task automatic step;
    logic [15:0] c;
    @(posedge clk_sys);
    c = m_cnt;
    if (clk_en && !rst)
    begin
      m_fl = m_fl & ~flag_clear;
      if (capture_pin_two && !m_q2)
      begin
        m_c2 = c;
        m_fl[0] = 1;
      end
      if (capture_pin_one && !m_q1 && !ctrl.pwm_mode)
      begin
        m_c1 = c;
        m_fl[1] = 1;
      end
      m_q1 = capture_pin_one;
      m_q2 = capture_pin_two;
      if (ext_tick && ctrl.pwm_mode && c == m_s[1])
      begin
        m_cnt = 16'hFFFC;
        m_pin = ctrl.period_match_level;
        m_fl[1] = 1;
        m_s = m_v;
      end
      else if (ext_tick)
      begin
        m_cnt = c + 16'h0001;
        if (c == m_s[0])
          m_pin = ctrl.first_match_level;
        if (!ctrl.pwm_mode)
          m_fl[3:2] = m_fl[3:2] | {c == m_s[0], c == m_s[1]};
      end
      if (!ctrl.pwm_mode)
        m_s = m_v;
      // Writes land after the shadows took the old value
      if (cmp_wr_high)
        m_hi[cmp_wr_sel] = cmp_wr_byte;
      else if (cmp_wr_low)
        m_v[cmp_wr_sel] = {m_hi[cmp_wr_sel], cmp_wr_byte};
    end
    if (rst)
    begin
      m_cnt = 16'hFFFC;
      m_c1 = 16'h0000;
      m_c2 = 16'h0000;
      m_v = '{2{16'h0000}};
      m_s = '{2{16'h0000}};
      m_hi = '{2{8'h00}};
      m_fl = 4'h0;
      m_pin = 0;
      m_q1 = 0;
      m_q2 = 0;
    end
    #1;
    if (chk)
    begin
      check(counter, m_cnt);
      check(16'(flags), 16'(m_fl));
      check(first_capture_value, m_c1);
      check(second_capture_value, m_c2);
      check(16'(timer_irq), 16'(ctrl.capture_irq_enable
        & ~ctrl.global_irq_mask & (m_fl[1] | m_fl[0])));
      check(16'(waveform_output_oe), 16'(ctrl.compare1_pin_enable));
      if (ctrl.pwm_mode)
        check(16'(waveform_output_pin),
          16'(m_pin & ctrl.compare1_pin_enable));
    end
  endtask

  // One compare byte write; the caller drops the strobes afterwards
  task automatic put(input logic hi, input logic sel, input logic [7:0] b);
    cmp_wr_high = hi;
    cmp_wr_low = !hi;
    cmp_wr_sel = sel;
    cmp_wr_byte = b;
    step;
  endtask

  // Hang guard
  initial
  begin
    #3000000;
    miscompares++;
    end_of_test;
  end

  // Main sequence
  initial
  begin
    repeat (16) step;
    rst = 0;
    chk = 1;
    put(1, 0, 8'h00);
    put(0, 0, 8'h02);
    put(1, 1, 8'h00);
    put(0, 1, 8'h20);
    cmp_wr_high = 0;
    cmp_wr_low = 0;
    // Plain compare first, then the mode
    ext_tick = 1;
    repeat (10) step;
    ext_tick = 0;
    flag_clear = '1;
    step;
    flag_clear = '0;
    ctrl = 9'h16E;
    repeat (4000)
    begin
      r = $random(seed);
      r2 = $random(seed);
      ext_tick = r[0] | r[1];
      clk_en = |r[4:2];
      capture_pin_one = r[5];
      capture_pin_two = r[6] & r[7];
      flag_clear = tpwm_clear_s'(r[12:8] == 5'h00 ? r[16:13] : 4'h0);
      if (r[23:17] == 7'h00)
        ctrl = {ctrl[8], r2[10:7], ctrl[3:2], r2[12:11]};
      // Compare byte write, which may meet a tick
      cmp_wr_high = (r[27:25] == 3'h0) & r[28];
      cmp_wr_low = (r[27:25] == 3'h0) & !r[28];
      cmp_wr_sel = r[29];
      cmp_wr_byte = r[28] ? {7'h00, r2[6]} : {2'h0, r2[5:0]};
      step;
    end
    // Prescaler periods seen by the load
    chk = 0;
    ext_tick = 0;
    clk_en = 1;
    capture_pin_one = 0;
    capture_pin_two = 0;
    flag_clear = '0;
    ctrl = 9'h16E;
    put(1, 0, 8'h00);
    put(0, 0, 8'h02);
    put(1, 1, 8'h00);
    put(0, 1, 8'h06);
    cmp_wr_high = 0;
    cmp_wr_low = 0;
    for (int k = 0; k < 3; k++)
    begin
      ctrl.timer_clock_select = 2'(k);
      repeat (2500) step;
      check(16'(mon_period),
        16'((6 + int'(TPWM_TICK_OFFSET)) * dv[k]));
      check(16'(mon_high), 16'(4 * dv[k]));
    end
    // Single shot restart with the mode bit clear
    ctrl = 9'h0DC;
    capture_pin_one = 1;
    step;
    check(counter, TPWM_RELOAD);
    check(16'(waveform_output_pin), 16'h0001);
    capture_pin_one = 0;
    ext_tick = 1;
    repeat (6) step;
    check(16'(waveform_output_pin), 16'h0001);
    check(16'(flags.compare1_flag), 16'h0000);
    step;
    check(16'(waveform_output_pin), 16'h0000);
    check(16'(flags.compare1_flag), 16'h0001);
    end_of_test;
  end
endmodule // tpwm_timer_bench
